/* File: adc_link_pkg.sv */
// Shared constants for the isolated ADC front end and its metering partner
package adc_link_pkg;
    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned MASTER_HZ         = 4_096_000;
    localparam int unsigned SYNC_HZ           = 1_024_000;
    localparam int unsigned RESET_TOGGLES     = 4;
    localparam int unsigned SLOT_COUNT        = 8;
    localparam int unsigned FRAME_BITS        = 16;
    // Half periods rounded down, never below one cycle
    localparam int unsigned MCLK_HALF_CYC     = (CLK_HZ / MASTER_HZ / 2) < 1 ? 1 : CLK_HZ / MASTER_HZ / 2;
    localparam int unsigned SYNC_HALF_CYC     = (CLK_HZ / SYNC_HZ / 2) < 1 ? 1 : CLK_HZ / SYNC_HZ / 2;
    localparam logic        SEL_VOLTAGE       = 1'b1;
    localparam logic        STREAM_IDLE       = 1'b1;
endpackage

/* File: adc_link_if.sv */
// Pin-level link between front end and metering partner
`timescale 1ns/1ps
interface adc_link_if;
    logic master_clock;
    logic sync_clock;
    logic channel_temp_select;
    logic reset_arm_b;
    logic data;

    modport front_end (
        input  master_clock,
        input  sync_clock,
        input  channel_temp_select,
        input  reset_arm_b,
        output data
    );
    modport partner (
        output master_clock,
        output sync_clock,
        output channel_temp_select,
        output reset_arm_b,
        input  data
    );
endinterface

/* File: adc_front_end.sv */
// Isolated ADC front end: select, reset handshake, slots and stream out
`timescale 1ns/1ps
module adc_front_end #(
    parameter bit          TWO_CHANNEL = 1'b0,
    parameter int unsigned WORD_W      = 16
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    // Link to partner
    adc_link_if.front_end          link,
    // Static straps
    input  wire logic              emission_slot_select_i,
    // Conversion results to send
    input  wire logic [WORD_W-1:0] word_i,
    input  wire logic              word_valid_i,
    output logic                   word_ready_o,
    // Status
    output logic                   in_reset_o,
    output logic                   converts_voltage_o,
    output logic                   pulse_o,
    output logic [2:0]             slot_o
);
    typedef enum logic [1:0] {RUN, ARMED, HELD} rst_state_e;

    // Three-stage synchronisers; only stages two and three are compared
    logic [2:0] sel_sq, arm_sq, mck_sq, syn_sq;
    logic       sel_f_q, arm_f_q, mck_f_q, syn_f_q;
    logic       sel_f_d, arm_f_d, mck_f_d, syn_f_d;
    always_comb begin
        sel_f_d = (sel_sq[1] == sel_sq[2]) ? sel_sq[2] : sel_f_q;
        arm_f_d = (arm_sq[1] == arm_sq[2]) ? arm_sq[2] : arm_f_q;
        mck_f_d = (mck_sq[1] == mck_sq[2]) ? mck_sq[2] : mck_f_q;
        syn_f_d = (syn_sq[1] == syn_sq[2]) ? syn_sq[2] : syn_f_q;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            // Match each pin's idle level, so no false edge follows reset
            sel_sq  <= 3'b111;
            arm_sq  <= 3'b111;
            mck_sq  <= 3'b000;
            syn_sq  <= 3'b000;
            sel_f_q <= 1'b1;
            arm_f_q <= 1'b1;
            mck_f_q <= 1'b0;
            syn_f_q <= 1'b0;
        end else if (ce_i) begin
            sel_sq <= {sel_sq[1:0], link.channel_temp_select};
            arm_sq <= {arm_sq[1:0], link.reset_arm_b};
            mck_sq <= {mck_sq[1:0], link.master_clock};
            syn_sq <= {syn_sq[1:0], link.sync_clock};
            sel_f_q <= sel_f_d;
            arm_f_q <= arm_f_d;
            mck_f_q <= mck_f_d;
            syn_f_q <= syn_f_d;
        end
    end

    wire sel_edge = sel_f_d != sel_f_q;
    wire mck_rise = mck_f_d & ~mck_f_q;
    wire syn_fall = ~syn_f_d & syn_f_q;

    // Reset handshake
    rst_state_e st_q, st_d;
    logic [2:0] tog_q, tog_d;
    always_comb begin
        st_d  = st_q;
        tog_d = tog_q;
        case (st_q)
            RUN: begin
                if (!arm_f_q) begin
                    st_d  = ARMED;
                    tog_d = '0;
                end
            end
            ARMED: begin
                if (arm_f_q) begin
                    st_d  = RUN;
                    tog_d = '0;
                end else if (sel_edge) begin
                    tog_d = tog_q + 3'd1;
                    if (tog_d == 3'(adc_link_pkg::RESET_TOGGLES))
                        st_d = HELD;
                end
            end
            HELD: begin
                tog_d = '0;
                if (arm_f_q && sel_f_q)
                    st_d = RUN;
            end
            default: st_d = RUN;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q  <= RUN;
            tog_q <= '0;
        end else if (ce_i) begin
            st_q  <= st_d;
            tog_q <= tog_d;
        end
    end
    assign in_reset_o = st_q == HELD;

    // Channel selection
    logic conv_v_q, conv_v_d;
    always_comb begin
        conv_v_d = TWO_CHANNEL ? 1'b0
                              : (sel_f_q == adc_link_pkg::SEL_VOLTAGE);
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i)       conv_v_q <= 1'b0;
        else if (ce_i)      conv_v_q <= conv_v_d;
    end
    assign converts_voltage_o = conv_v_q;

    // Converter slots advance on master clock rises
    logic [2:0] slot_q, slot_d;
    logic       pulse_q, pulse_d;
    always_comb begin
        slot_d = slot_q;
        if (in_reset_o) begin
            slot_d = '0;
        end else if (mck_rise) begin
            slot_d = slot_q + 3'd1;
        end
        // Pulse follows the slot it belongs to, slot 0 included
        pulse_d = !in_reset_o && (slot_d[0] == emission_slot_select_i);
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            slot_q  <= '0;
            pulse_q <= 1'b0;
        end else if (ce_i) begin
            slot_q  <= slot_d;
            pulse_q <= pulse_d;
        end
    end
    assign pulse_o = pulse_q;
    assign slot_o  = slot_q;

    // Two-entry buffer ahead of the serialiser
    logic [WORD_W-1:0] buf_q [2];
    logic [WORD_W-1:0] buf_d [2];
    logic [1:0]        cnt_q, cnt_d;
    logic [WORD_W-1:0] sh_q, sh_d;
    logic [$clog2(WORD_W+1)-1:0] bits_q, bits_d;
    logic              dout_q, dout_d;
    wire push = word_valid_i && word_ready_o;
    wire load = syn_fall && bits_q == '0 && cnt_q != 2'd0 && !in_reset_o;
    assign word_ready_o = cnt_q != 2'd2 && !in_reset_o;
    always_comb begin
        buf_d  = buf_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        bits_d = bits_q;
        dout_d = dout_q;
        if (in_reset_o) begin
            cnt_d  = '0;
            bits_d = '0;
            dout_d = adc_link_pkg::STREAM_IDLE;
        end else if (syn_fall) begin
            // Bits change on sync falling edge, partner samples on rise
            if (load) begin
                {dout_d, sh_d} = {buf_q[0], 1'b0};
                bits_d = ($clog2(WORD_W+1))'(WORD_W - 1);
                buf_d[0] = buf_q[1];
                cnt_d = cnt_q - 2'd1;
            end else if (bits_q != '0) begin
                {dout_d, sh_d} = {sh_q, 1'b0};
                bits_d = bits_q - 1'b1;
            end else begin
                dout_d = adc_link_pkg::STREAM_IDLE;
            end
        end
        if (push) begin
            buf_d[cnt_d[0] ? 1 : 0] = word_i;
            cnt_d = cnt_d + 2'd1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            cnt_q    <= '0;
            sh_q     <= '0;
            bits_q   <= '0;
            dout_q   <= adc_link_pkg::STREAM_IDLE;
        end else if (ce_i) begin
            buf_q  <= buf_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            bits_q <= bits_d;
            dout_q <= dout_d;
        end
    end
    assign link.data = dout_q;
endmodule

/* File: meter_partner.sv */
// Metering partner end: clocks, select drive, reset sequence, stream capture
`timescale 1ns/1ps
module meter_partner #(
    parameter int unsigned WORD_W = 16
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    // Link to front end
    adc_link_if.partner            link,
    // Control
    input  wire logic              select_voltage_i,
    input  wire logic              reset_req_i,
    output logic                   reset_busy_o,
    // Received words
    output logic [WORD_W-1:0]      word_o,
    output logic                   word_valid_o
);
    typedef enum logic [1:0] {IDLE, ARM, TOGGLE, RELEASE} seq_e;

    logic [7:0] mdiv_q, mdiv_d, sdiv_q, sdiv_d;
    logic       mclk_q, mclk_d, sclk_q, sclk_d;
    seq_e       st_q, st_d;
    logic [3:0] ecnt_q, ecnt_d;
    logic       sel_q, sel_d, arm_q, arm_d;
    logic [2:0] din_sq;
    logic       din_f_q, din_f_d;
    logic [WORD_W-1:0] sh_q, sh_d, word_q, word_d;
    logic [$clog2(WORD_W+1)-1:0] bits_q, bits_d;
    logic       vld_q, vld_d, busy_d;

    wire mrise = mdiv_q == 8'(adc_link_pkg::MCLK_HALF_CYC - 1) && !mclk_q;
    wire srise = sdiv_q == 8'(adc_link_pkg::SYNC_HALF_CYC - 1) && !sclk_q;

    always_comb begin
        mdiv_d = mdiv_q + 8'd1;
        mclk_d = mclk_q;
        if (mdiv_q == 8'(adc_link_pkg::MCLK_HALF_CYC - 1)) begin
            mdiv_d = '0;
            mclk_d = ~mclk_q;
        end
        sdiv_d = sdiv_q + 8'd1;
        sclk_d = sclk_q;
        if (sdiv_q == 8'(adc_link_pkg::SYNC_HALF_CYC - 1)) begin
            sdiv_d = '0;
            sclk_d = ~sclk_q;
        end
        st_d   = st_q;
        ecnt_d = ecnt_q;
        sel_d  = sel_q;
        arm_d  = arm_q;
        busy_d = 1'b1;
        case (st_q)
            IDLE: begin
                busy_d = 1'b0;
                arm_d  = 1'b1;
                sel_d  = select_voltage_i;
                if (reset_req_i) begin
                    st_d  = ARM;
                    arm_d = 1'b0;
                    busy_d = 1'b1;
                end
            end
            ARM: begin
                if (mrise) begin
                    st_d   = TOGGLE;
                    ecnt_d = '0;
                end
            end
            TOGGLE: begin
                // Toggle on each master clock rise, at that clock's rate
                if (mrise) begin
                    sel_d  = ~sel_q;
                    ecnt_d = ecnt_q + 4'd1;
                    if (ecnt_q == 4'(adc_link_pkg::RESET_TOGGLES - 1))
                        st_d = RELEASE;
                end
            end
            RELEASE: begin
                if (mrise) begin
                    arm_d = 1'b1;
                    sel_d = 1'b1;
                    st_d  = IDLE;
                end
            end
            default: st_d = IDLE;
        endcase
        din_f_d = (din_sq[1] == din_sq[2]) ? din_sq[2] : din_f_q;
        sh_d    = sh_q;
        bits_d  = bits_q;
        word_d  = word_q;
        vld_d   = 1'b0;
        // Idle level is high; a low bit starts a word
        if (srise) begin
            if (bits_q != '0) begin
                sh_d   = {sh_q[WORD_W-2:0], din_f_q};
                bits_d = bits_q - 1'b1;
                if (bits_q == 1) begin
                    word_d = {sh_q[WORD_W-2:0], din_f_q};
                    vld_d  = 1'b1;
                end
            end else if (din_f_q != adc_link_pkg::STREAM_IDLE) begin
                sh_d   = {{(WORD_W-1){1'b0}}, din_f_q};
                bits_d = ($clog2(WORD_W+1))'(WORD_W - 1);
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mdiv_q <= '0;  mclk_q <= 1'b0;
            sdiv_q <= '0;  sclk_q <= 1'b0;
            st_q <= IDLE;  ecnt_q <= '0;
            sel_q <= 1'b1; arm_q  <= 1'b1;
            din_sq <= 3'h7; din_f_q <= 1'b1;
            sh_q <= '0; bits_q <= '0; word_q <= '0; vld_q <= 1'b0;
            reset_busy_o <= 1'b0;
        end else if (ce_i) begin
            mdiv_q <= mdiv_d;  mclk_q <= mclk_d;
            sdiv_q <= sdiv_d;  sclk_q <= sclk_d;
            st_q <= st_d;      ecnt_q <= ecnt_d;
            sel_q <= sel_d;    arm_q  <= arm_d;
            din_sq <= {din_sq[1:0], link.data};
            din_f_q <= din_f_d;
            sh_q <= sh_d; bits_q <= bits_d; word_q <= word_d; vld_q <= vld_d;
            reset_busy_o <= busy_d;
        end
    end
    assign link.master_clock        = mclk_q;
    assign link.sync_clock          = sclk_q;
    assign link.channel_temp_select = sel_q;
    assign link.reset_arm_b         = arm_q;
    assign word_o       = word_q;
    assign word_valid_o = vld_q;
endmodule

/* File: adc_link_sva.sv */
// Link checker: reset handshake, slots, select and stream timing
`timescale 1ns/1ps
module adc_link_sva (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic       ce_i,
    // Link pins
    input wire logic       master_clock,
    input wire logic       sync_clock,
    input wire logic       channel_temp_select,
    input wire logic       reset_arm_b,
    input wire logic       data,
    // Front end status
    input wire logic       emission_slot_select_i,
    input wire logic       in_reset_o,
    input wire logic       converts_voltage_o,
    input wire logic       pulse_o,
    input wire logic [2:0] slot_o
);
    localparam int MCLK_P = 2 * adc_link_pkg::MCLK_HALF_CYC;
    localparam int SYNC_P = 2 * adc_link_pkg::SYNC_HALF_CYC;
    logic [7:0] arm_q, arm_d;
    logic [3:0] sel_q, sel_d;
    logic [2:0] tog_q, tog_d;
    logic [4:0] fall_q, fall_d;
    logic       snc_q, snc_d;
    default clocking cb @(posedge clk_i); endclocking
    // A frozen block stretches every timing window, so checks pause with it
    default disable iff (!rst_b_i || !ce_i);
    // Delays trail the front end's synchronisers; clear lags so a late entry still sees the count
    always_comb begin
        arm_d = {arm_q[6:0], reset_arm_b};
        sel_d = {sel_q[2:0], channel_temp_select};
        snc_d = sync_clock;
        tog_d = tog_q;
        if (arm_q[7]) begin
            tog_d = 3'h0;
        end else if (!arm_q[3] && (sel_q[3] ^ sel_q[2]) && tog_q != 3'h7) begin
            tog_d = tog_q + 3'h1;
        end
        fall_d = (snc_q && !sync_clock) ? 5'h0 : (fall_q == 5'h1f ? fall_q : fall_q + 5'h1);
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            arm_q  <= 8'hff;
            sel_q  <= 4'hf;
            tog_q  <= 3'h0;
            fall_q <= 5'h1f;
            snc_q  <= 1'b0;
        end else begin
            arm_q  <= arm_d;
            sel_q  <= sel_d;
            tog_q  <= tog_d;
            fall_q <= fall_d;
            snc_q  <= snc_d;
        end
    end
    sequence fourth_toggle_s;
        $rose(tog_q == 3'h4);
    endsequence
    sequence arm_sel_high_s;
        (reset_arm_b && channel_temp_select) [*8];
    endsequence
    reset_entry_a: assert property (fourth_toggle_s |-> ##[0:8] in_reset_o)
        else $error("reset not entered after four toggles");
    reset_cause_a: assert property ($rose(in_reset_o) |-> tog_q >= 3'h4)
        else $error("reset entered without four armed toggles");
    reset_exit_a: assert property (arm_sel_high_s |-> ##2 !in_reset_o)
        else $error("reset held with arm and select high");
    reset_hold_a: assert property (in_reset_o && !reset_arm_b && !arm_q[3] |=> in_reset_o)
        else $error("reset left while arm low");
    sel_follow_a: assert property ((!in_reset_o && $stable(channel_temp_select)) [*8]
        |-> converts_voltage_o == channel_temp_select)
        else $error("channel choice does not follow select");
    slot_parity_a: assert property (pulse_o && $stable(slot_o) |-> slot_o[0] == emission_slot_select_i)
        else $error("pulse in a disabled slot");
    pulse_present_a: assert property ((!in_reset_o && slot_o[0] == emission_slot_select_i) [*3] |-> pulse_o)
        else $error("no pulse in an enabled slot");
    slot_step_a: assert property ($rose(master_clock) && !in_reset_o
        |-> ##[1:6] ($changed(slot_o) || in_reset_o))
        else $error("slot did not advance on master clock");
    mclk_period_a: assert property ($rose(master_clock) |-> ##MCLK_P $rose(master_clock))
        else $error("master clock period wrong");
    sync_period_a: assert property ($rose(sync_clock) |-> ##SYNC_P $rose(sync_clock))
        else $error("sync clock period wrong");
    data_edge_a: assert property ($changed(data) |-> fall_q <= 5'h8)
        else $error("data moved away from a sync falling edge");
endmodule

/* File: tb_top.sv */
// Top bench: front end and partner joined, plus a bench-driven front end
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
`define WAITB(c) begin k = 0; while (!(c) && k < 4000) begin @(posedge clk_i); k++; end if (!(c)) begin n_fail++; report_and_stop(); end end
module tb_top;
    logic        clk_i, rst_b_i, ce_i, sel_v, rst_req, busy, slot_sel, saw_full, saw_rst;
    logic [15:0] word_i, word_o, w;
    logic        word_valid_i, word_ready_o, word_valid_o;
    logic        in_reset_o, conv, pulse, in_reset_b, conv_b, pulse_b;
    logic [2:0]  slot, slot_b, sp, sp_b;
    logic [15:0] expq[$];
    logic [15:0] vecs [4] = '{16'h1234, 16'h0001, 16'h7fff, 16'h0000};
    int          n_fail, checked, k, npa, npb;
    adc_link_if link_if();
    adc_link_if link_b();
    adc_front_end #(.TWO_CHANNEL(1'b0), .WORD_W(16)) i_adc_front_end (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .link(link_if), .emission_slot_select_i(slot_sel), .word_i(word_i), .word_valid_i(word_valid_i),
        .word_ready_o(word_ready_o), .in_reset_o(in_reset_o), .converts_voltage_o(conv), .pulse_o(pulse), .slot_o(slot));
    adc_front_end #(.TWO_CHANNEL(1'b1), .WORD_W(16)) i_adc_front_end_b (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .link(link_b), .emission_slot_select_i(!slot_sel), .word_i(word_i), .word_valid_i(word_valid_i),
        .word_ready_o(), .in_reset_o(in_reset_b), .converts_voltage_o(conv_b), .pulse_o(pulse_b), .slot_o(slot_b));
    meter_partner #(.WORD_W(16)) i_meter_partner (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .link(link_if),
        .select_voltage_i(sel_v), .reset_req_i(rst_req), .reset_busy_o(busy), .word_o(word_o), .word_valid_o(word_valid_o));
    adc_link_sva i_adc_link_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .master_clock(link_if.master_clock),
        .sync_clock(link_if.sync_clock), .channel_temp_select(link_if.channel_temp_select),
        .reset_arm_b(link_if.reset_arm_b), .data(link_if.data), .emission_slot_select_i(slot_sel),
        .in_reset_o(in_reset_o), .converts_voltage_o(conv), .pulse_o(pulse), .slot_o(slot));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Bench-made master clock; sync stays still as no frames run here
    always #160 link_b.master_clock = ~link_b.master_clock;
    always @(posedge clk_i) begin
        if (word_valid_o === 1'b1) begin
            `CHK(expq.size() != 0, 1'b1)
            if (expq.size() != 0) begin
                w = expq.pop_front();
                `CHK(word_o, w)
            end
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // MSB must be 0: the partner starts a frame on the first low bit
    task automatic send(input logic [15:0] v);
        word_i       <= v;
        word_valid_i <= 1'b1;
        expq.push_back(v);
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
            if (word_ready_o !== 1'b1) saw_full = 1'b1;
        end while (word_ready_o !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic toggle_b(input int n);
        repeat (n) begin
            repeat (adc_link_pkg::MCLK_HALF_CYC) @(posedge clk_i);
            link_b.channel_temp_select <= !link_b.channel_temp_select;
        end
    endtask
    initial begin
        rst_b_i = 1'b0; ce_i = 1'b1; sel_v = 1'b1; rst_req = 1'b0; slot_sel = 1'b0;
        word_i = 16'h0000; word_valid_i = 1'b0; n_fail = 0; checked = 0; npa = 0; npb = 0;
        saw_full = 1'b0; saw_rst = 1'b0; sp = 3'h0; sp_b = 3'h0;
        link_b.master_clock = 1'b0; link_b.sync_clock = 1'b0;
        link_b.channel_temp_select = 1'b1; link_b.reset_arm_b = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 2; i++) begin
            sel_v <= i[0];
            link_b.channel_temp_select <= i[0];
            repeat (16) @(posedge clk_i);
            `CHK(conv, i[0])
            `CHK(conv_b, 1'b0)
        end
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_i);
            if (pulse === 1'b1 && slot === sp) begin
                `CHK(slot[0], 1'b0)
                npa++;
            end
            if (pulse_b === 1'b1 && slot_b === sp_b) begin
                `CHK(slot_b[0], 1'b1)
                npb++;
            end
            sp = slot;
            sp_b = slot_b;
        end
        `CHK(npa > 0, 1'b1)
        `CHK(npb > 0, 1'b1)
        ce_i <= 1'b0;
        @(posedge clk_i);
        sp = slot;
        repeat (20) @(posedge clk_i);
        `CHK(slot, sp)
        ce_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        foreach (vecs[j]) send(vecs[j]);
        word_valid_i <= 1'b0;
        `WAITB(expq.size() == 0)
        `CHK(saw_full, 1'b1)
        repeat (60) @(posedge clk_i);
        `CHK(link_if.data, adc_link_pkg::STREAM_IDLE)
        rst_req <= 1'b1;
        `WAITB(busy === 1'b1)
        rst_req <= 1'b0;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk_i);
            if (in_reset_o === 1'b1) saw_rst = 1'b1;
        end
        `CHK(saw_rst, 1'b1)
        `CHK(in_reset_o, 1'b0)
        link_b.reset_arm_b <= 1'b0;
        toggle_b(3);
        link_b.reset_arm_b <= 1'b1;
        repeat (8) @(posedge clk_i);
        link_b.reset_arm_b <= 1'b0;
        toggle_b(2);
        repeat (8) @(posedge clk_i);
        `CHK(in_reset_b, 1'b0)
        toggle_b(2);
        repeat (10) @(posedge clk_i);
        `CHK(in_reset_b, 1'b1)
        link_b.reset_arm_b <= 1'b1;
        repeat (10) @(posedge clk_i);
        `CHK(in_reset_b, 1'b1)
        link_b.channel_temp_select <= 1'b1;
        repeat (10) @(posedge clk_i);
        `CHK(in_reset_b, 1'b0)
        report_and_stop();
    end
endmodule
